// ### rtl/htx_insert.sv
// How it works
// - ESF and T1 DM formats: all three transmitters insert into the stream.
// - SF and SLC-96 formats: only transmitters two and three are usable.
// - E1 mode: all three transmitters are usable for insertion.
// - Transmitter one uses link bit (ESF) or channel 24 D bit (DM), fixed unless framing bypass gives it its slot.
// - Even/odd select bits choose which frame parities get insertion.
// - Five-bit slot field picks the channel or timeslot to write.
// - Eight-bit mask picks which bits of that slot are replaced.
// - A transmitter does nothing unless its own enable bit is one.
// - Protocol select zero (reset value) gives HDLC framing.
// - Framing bypass lets stream reach transmitters with no frame positions.
`timescale 1ns/1ns
`default_nettype none
module htx_insert (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [htx_pkg::AW-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq,
  input  wire logic                  inValid,
  input  wire logic                  inBit,
  input  wire logic                  frameOdd,
  input  wire logic [4:0]            slotIdx,
  input  wire logic [2:0]            bitIdx,
  input  wire logic                  framingPos,
  input  wire logic                  facilityLinkPos,
  output logic                       outValid,
  output logic                       outBit
);
  import htx_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  logic [7:0]  idx;
  logic        wrAcc;
  logic        setupCyc;
  logic        mapped;
  logic [2:0]  hdlc_tx_enable;
  logic [2:0]  fmtRaw;
  htx_fmt_e    fmt;
  logic        framing_bypass;
  logic [7:0]  channel_slot_pick [NTX];
  logic [7:0]  lane_bit_mask     [NTX];
  logic [7:0]  linkCtrl          [NTX];
  logic [7:0]  fifoLevels        [NTX];
  logic [7:0]  evMask            [NTX];
  logic [1:0]  evFlags           [NTX];
  logic [7:0]  fifoState         [NTX];
  logic [NTX-1:0] sel;
  logic [NTX-1:0] tBit;
  logic [NTX-1:0] spaceEv;
  logic [NTX-1:0] underEv;
  logic [NTX-1:0] irqVec;
  logic [NTX-1:0] wrOct;
  logic        next_outBit;
  logic [31:0] next_prdata;

  assign idx      = paddr[9:2];
  assign wrAcc    = psel && penable && pwrite;
  assign setupCyc = psel && !penable;
  assign fmt      = htx_fmt_e'(fmtRaw);

  //////////////////////////////////////////////////////////////////////////
  // Bus slave

  always_comb begin
    mapped = (paddr[AW-1:10] == '0) && (paddr[1:0] == 2'b00) &&
             (idx == IDX_EN || idx == IDX_EVFLAG3 ||
              idx == IDX_EVACK || idx == IDX_FORMAT);
    for (int i = 0; i < NTX; i++) begin
      if (idx == IDX_FIFO_ST[i] || idx == IDX_ASSIGN[i] ||
          idx == IDX_BITMASK[i] || idx == IDX_CTRL[i] ||
          idx == IDX_LEVELS[i] || idx == IDX_OCTET[i] ||
          idx == IDX_EVMASK[i])
        mapped = (paddr[AW-1:10] == '0) && (paddr[1:0] == 2'b00);
    end
  end

  // Shared offsets read back the event flags; writes load the assignment
  always_comb begin
    next_prdata = 32'h0000_0000;
    for (int i = 0; i < NTX; i++) begin
      if (idx == IDX_FIFO_ST[i]) next_prdata[7:0] = fifoState[i];
      if (idx == IDX_ASSIGN[i])  next_prdata[7:0] = channel_slot_pick[i];
      if (idx == IDX_BITMASK[i]) next_prdata[7:0] = lane_bit_mask[i];
      if (idx == IDX_CTRL[i])    next_prdata[7:0] = linkCtrl[i];
      if (idx == IDX_LEVELS[i])  next_prdata[7:0] = fifoLevels[i];
      if (idx == IDX_EVMASK[i])  next_prdata[7:0] = evMask[i];
    end
    if (idx == IDX_ASSIGN[1])  next_prdata[7:0] = {6'h00, evFlags[0]};
    if (idx == IDX_ASSIGN[2])  next_prdata[7:0] = {6'h00, evFlags[1]};
    if (idx == IDX_EVFLAG3)    next_prdata[7:0] = {6'h00, evFlags[2]};
    if (idx == IDX_EN)         next_prdata[7:0] = {5'h00, hdlc_tx_enable};
    if (idx == IDX_EVACK)
      next_prdata[7:0] = {2'b00, evFlags[2], evFlags[1], evFlags[0]};
    if (idx == IDX_FORMAT)
      next_prdata[7:0] = {4'h0, framing_bypass, fmtRaw};
    if (!mapped) next_prdata = 32'h0000_0000;
  end

  // Read data and error are captured in setup, so access ends at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupCyc) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !mapped;
    end
  end

  assign pready = 1'b1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdlc_tx_enable <= RST_REG[2:0];
      fmtRaw         <= RST_FMT;
      framing_bypass <= 1'b0;
    end else if (wrAcc && mapped) begin
      if (idx == IDX_EN) hdlc_tx_enable <= pwdata[2:0];
      if (idx == IDX_FORMAT) begin
        fmtRaw         <= pwdata[2:0];
        framing_bypass <= pwdata[FMT_BYPASS];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-transmitter configuration, engine and events

  for (genvar g = 0; g < NTX; g++) begin : gTx
    htx_tx_e    st;
    logic [7:0] hold;
    logic       holdValid;
    logic       holdEom;
    logic [7:0] shift;
    logic       curEom;
    logic [2:0] cnt;
    logic [2:0] ones;
    logic       proto;
    logic       stuffNow;
    logic       fixedFmt;
    logic       usable;
    logic       fixedHit;
    logic       parityOk;
    logic       progHit;
    logic       lastBit;

    assign wrOct[g] = wrAcc && mapped && idx == IDX_OCTET[g];
    assign proto    = linkCtrl[g][CTL_PROTO];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        channel_slot_pick[g] <= RST_REG;
        lane_bit_mask[g]     <= RST_REG;
        linkCtrl[g]          <= RST_REG;
        fifoLevels[g]        <= RST_REG;
        evMask[g]            <= RST_REG;
      end else begin
        if (wrAcc && mapped) begin
          if (idx == IDX_ASSIGN[g])  channel_slot_pick[g] <= pwdata[7:0];
          if (idx == IDX_BITMASK[g]) lane_bit_mask[g]     <= pwdata[7:0];
          if (idx == IDX_CTRL[g])    linkCtrl[g]          <= pwdata[7:0];
          if (idx == IDX_LEVELS[g])  fifoLevels[g]        <= pwdata[7:0];
          if (idx == IDX_EVMASK[g])  evMask[g]            <= pwdata[7:0];
        end
        // End-of-message is consumed by the octet written after it
        if (wrOct[g] && hdlc_tx_enable[g] && !holdValid)
          linkCtrl[g][CTL_EOM] <= 1'b0;
      end
    end

    // Position match
    // Bypass leaves no link bit, so transmitter one falls back to its slot
    assign fixedFmt = (g == 0) && !framing_bypass &&
                      (fmt == FMT_ESF || fmt == FMT_T1DM);
    assign usable   = !((g == 0) && (fmt == FMT_SF || fmt == FMT_SLC96));
    assign fixedHit = !framing_bypass &&
                      ((fmt == FMT_ESF) ? facilityLinkPos :
                       (slotIdx == LAST_CH && bitIdx == DBIT_IDX &&
                        !framingPos));
    assign parityOk = frameOdd ? channel_slot_pick[g][ASG_ODD]
                               : channel_slot_pick[g][ASG_EVEN];
    // Bypass drops framing positions so every bit is payload
    assign progHit  = parityOk &&
                      slotIdx == channel_slot_pick[g][4:0] &&
                      lane_bit_mask[g][bitIdx] &&
                      (framing_bypass || !framingPos);
    assign sel[g]   = inValid && hdlc_tx_enable[g] && usable &&
                      (fixedFmt ? fixedHit : progHit);

    // Serialiser
    // A run that ends the last octet is stuffed before the closing flag
    assign stuffNow = (st == TX_DATA || cnt == 3'h0) && !proto &&
                      ones == STUFF_RUN;
    assign lastBit  = cnt == 3'h7;
    always_comb begin
      unique case (st)
        TX_FLAG: tBit[g] = FLAG_PAT[cnt];
        TX_DATA: tBit[g] = stuffNow ? 1'b0 : shift[0];
      endcase
    end

    assign spaceEv[g] = sel[g] && lastBit && holdValid && !stuffNow &&
                        (st == TX_FLAG || !curEom);
    assign underEv[g] = sel[g] && st == TX_DATA && lastBit && !stuffNow &&
                        !curEom && !holdValid;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        st        <= TX_FLAG;
        hold      <= 8'h00;
        holdValid <= 1'b0;
        holdEom   <= 1'b0;
        shift     <= 8'h00;
        curEom    <= 1'b0;
        cnt       <= 3'h0;
        ones      <= 3'h0;
      end else if (!hdlc_tx_enable[g]) begin
        st        <= TX_FLAG;
        holdValid <= 1'b0;
        cnt       <= 3'h0;
        ones      <= 3'h0;
      end else begin
        // A full holding register refuses further octets
        if (wrOct[g] && !holdValid) begin
          hold      <= pwdata[7:0];
          holdValid <= 1'b1;
          holdEom   <= linkCtrl[g][CTL_EOM];
        end
        if (sel[g]) begin
          if (stuffNow) begin
            ones <= 3'h0;
          end else begin
            cnt <= 3'(cnt + 3'h1);
            if (st == TX_DATA) begin
              ones  <= shift[0] ? 3'(ones + 3'h1) : 3'h0;
              shift <= {1'b0, shift[7:1]};
            end
            if (lastBit) begin
              if ((st == TX_FLAG || !curEom) && holdValid) begin
                st        <= TX_DATA;
                shift     <= hold;
                curEom    <= holdEom;
                holdValid <= 1'b0;
                // Flag ones do not count; a data run carries over octets
                if (st == TX_FLAG) ones <= 3'h0;
              end else begin
                // Closing flag, or flag fill after an underrun
                st <= TX_FLAG;
              end
            end
          end
        end
      end
    end

    always_comb begin
      fifoState[g]           = 8'h00;
      fifoState[g][ST_FULL]  = holdValid;
      fifoState[g][ST_EMPTY] = !holdValid && st == TX_FLAG;
      fifoState[g][ST_READY] = !holdValid;
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        evFlags[g] <= 2'b00;
      end else begin
        evFlags[g] <= (evFlags[g] &
                       ~((wrAcc && mapped && idx == IDX_EVACK) ?
                         pwdata[2*g +: 2] : 2'b00)) |
                      {underEv[g], spaceEv[g]};
      end
    end

    assign irqVec[g] = |(evFlags[g] & evMask[g][1:0]);
  end

  assign irq = |irqVec;

  //////////////////////////////////////////////////////////////////////////
  // Output stream; lowest-numbered transmitter wins an overlap

  always_comb begin
    next_outBit = inBit;
    for (int i = NTX - 1; i >= 0; i--) begin
      if (sel[i]) next_outBit = tBit[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      outBit   <= 1'b1;
    end else begin
      outValid <= inValid;
      outBit   <= next_outBit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_en_wr;
    psel && penable && pwrite && idx == IDX_EN && paddr[11:10] == 2'b00
      && paddr[1:0] == 2'b00;
  endsequence
  sequence s_pass;
    inValid && sel == 3'b000;
  endsequence

  property p_pass;
    s_pass |=> outValid && outBit == $past(inBit);
  endproperty
  a_pass: assert property (p_pass) else $error("bit not passed");

  property p_en_load;
    s_en_wr |=> hdlc_tx_enable == $past(pwdata[2:0]);
  endproperty
  a_en_load: assert property (p_en_load) else $error("enable lost");

  property p_dis;
    hdlc_tx_enable == 3'b000 |-> sel == 3'b000;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled inserts");

  property p_sf;
    (fmt == FMT_SF || fmt == FMT_SLC96) |-> !sel[0];
  endproperty
  a_sf: assert property (p_sf) else $error("tx1 in SF");

  property p_esf;
    fmt == FMT_ESF && !framing_bypass && inValid && hdlc_tx_enable[0]
      |-> sel[0] == facilityLinkPos;
  endproperty
  a_esf: assert property (p_esf) else $error("tx1 link bit");

  property p_dm;
    sel[0] && fmt == FMT_T1DM && !framing_bypass |->
      slotIdx == LAST_CH && bitIdx == DBIT_IDX;
  endproperty
  a_dm: assert property (p_dm) else $error("tx1 D bit");

  property p_slot;
    sel[1] |-> slotIdx == channel_slot_pick[1][4:0] &&
               lane_bit_mask[1][bitIdx];
  endproperty
  a_slot: assert property (p_slot) else $error("slot or mask");

  property p_par;
    sel[2] |-> (frameOdd ? channel_slot_pick[2][ASG_ODD]
                         : channel_slot_pick[2][ASG_EVEN]);
  endproperty
  a_par: assert property (p_par) else $error("parity");

  property p_e1;
    fmt == FMT_E1 && inValid && hdlc_tx_enable[0] && !framingPos &&
      slotIdx == channel_slot_pick[0][4:0] && lane_bit_mask[0][bitIdx] &&
      (frameOdd ? channel_slot_pick[0][ASG_ODD]
                : channel_slot_pick[0][ASG_EVEN]) |-> sel[0];
  endproperty
  a_e1: assert property (p_e1) else $error("tx1 in E1");

  property p_stuff;
    sel[1] && gTx[1].stuffNow |=> !outBit;
  endproperty
  a_stuff: assert property (p_stuff) else $error("no stuff bit");

  property p_mask;
    inValid && hdlc_tx_enable[2] && !lane_bit_mask[2][bitIdx] |-> !sel[2];
  endproperty
  a_mask: assert property (p_mask) else $error("masked bit taken");
endmodule // htx_insert
`default_nettype wire

// ### rtl/htx_pkg.sv
`default_nettype none
package htx_pkg;
  localparam int NTX = 3;
  localparam int AW  = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FIFO_ST [NTX] = '{8'h80, 8'h81, 8'h82};
  localparam logic [7:0] IDX_EN            = 8'h84;
  localparam logic [7:0] IDX_ASSIGN  [NTX] = '{8'h85, 8'h86, 8'h87};
  localparam logic [7:0] IDX_BITMASK [NTX] = '{8'h88, 8'h89, 8'h8A};
  localparam logic [7:0] IDX_CTRL    [NTX] = '{8'hA7, 8'hA8, 8'hA9};
  localparam logic [7:0] IDX_LEVELS  [NTX] = '{8'hAA, 8'hAB, 8'hAC};
  localparam logic [7:0] IDX_OCTET   [NTX] = '{8'hAD, 8'hAE, 8'hAF};
  localparam logic [7:0] IDX_EVMASK  [NTX] = '{8'hB3, 8'hB4, 8'hB5};
  localparam logic [7:0] IDX_EVFLAG3       = 8'hB8;
  localparam logic [7:0] IDX_EVACK         = 8'hC0;
  localparam logic [7:0] IDX_FORMAT        = 8'hC1;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [2:0] RST_FMT = 3'h0;
  // Field positions
  localparam int ASG_EVEN   = 7;
  localparam int ASG_ODD    = 6;
  localparam int CTL_PROTO  = 0;
  localparam int CTL_EOM    = 1;
  localparam int FMT_BYPASS = 3;
  localparam int ST_FULL    = 0;
  localparam int ST_EMPTY   = 1;
  localparam int ST_READY   = 2;
  localparam int EV_SPACE   = 0;
  localparam int EV_UNDER   = 1;
  // Stream positions
  localparam logic [4:0] LAST_CH  = 5'h17;
  localparam logic [2:0] DBIT_IDX = 3'h7;
  localparam logic [7:0] FLAG_PAT = 8'h7E;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  typedef enum logic [2:0] {
    FMT_ESF, FMT_SF, FMT_SLC96, FMT_T1DM, FMT_E1
  } htx_fmt_e;
  typedef enum logic {TX_FLAG, TX_DATA} htx_tx_e;
endpackage
`default_nettype wire

// ### test/htx_line_src.sv
`timescale 1ns/1ns
`default_nettype none
module htx_line_src (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       isT1,
  input  wire logic       slow,
  input  wire logic       srcBit,
  output logic            inValid,
  output logic            inBit,
  output logic            frameOdd,
  output logic [4:0]      slotIdx,
  output logic [2:0]      bitIdx,
  output logic            framingPos,
  output logic            facilityLinkPos
);
  logic [8:0] pos;
  logic [7:0] k;
  logic       odd;
  logic       gap;
  logic       fbit;
  logic       last;
  assign fbit = isT1 && pos == 9'h000;
  // Compare with >= so a format switch mid-frame cannot run past the end
  assign last = pos >= (isT1 ? 9'h0C0 : 9'h0FF);
  assign k    = isT1 ? 8'(pos - 9'h001) : pos[7:0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {pos, odd, gap, inValid, inBit, frameOdd} <= '0;
      {slotIdx, bitIdx, framingPos, facilityLinkPos} <= '0;
    end else begin
      gap     <= slow & ~gap;
      inValid <= ~gap;
      // Idle cycles carry a toggling bit, never a stale copy
      inBit   <= gap ? ~inBit : srcBit;
      if (!gap) begin
        frameOdd        <= odd;
        framingPos      <= fbit;
        facilityLinkPos <= fbit && odd;
        slotIdx         <= fbit ? 5'h00 : k[7:3];
        bitIdx          <= fbit ? 3'h0 : k[2:0];
        pos             <= last ? 9'h000 : pos + 9'h001;
        odd             <= last ? ~odd : odd;
      end
    end
  end
endmodule // htx_line_src
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import htx_pkg::*;
  logic          clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rnd;
  logic          inValid, inBit, frameOdd, framingPos, facilityLinkPos;
  logic          outValid, outBit, isT1, slow, srcBit, byp, watch, pv, pb, er;
  logic [4:0]    slotIdx;
  logic [2:0]    bitIdx, en;
  logic [7:0]    rd, v, asg [3], msk [3];
  int            n_fail, tests_run, po, k;
  htx_fmt_e      fmt;
  logic          q [3][$];
  logic [7:0]    want [5];

  htx_insert DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .inValid(inValid),
    .inBit(inBit), .frameOdd(frameOdd), .slotIdx(slotIdx), .bitIdx(bitIdx),
    .framingPos(framingPos), .facilityLinkPos(facilityLinkPos),
    .outValid(outValid), .outBit(outBit));
  htx_line_src PARTNER (.clk(clk), .rst_n(rst_n), .isT1(isT1), .slow(slow),
    .srcBit(srcBit), .inValid(inValid), .inBit(inBit), .frameOdd(frameOdd),
    .slotIdx(slotIdx), .bitIdx(bitIdx), .framingPos(framingPos),
    .facilityLinkPos(facilityLinkPos));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    rnd    <= lfsr(rnd);
    srcBit <= rnd[7];
  end

  function automatic int owner(logic fo, logic [4:0] s, logic [2:0] b,
                               logic fp, logic fl);
    for (int t = 0; t < 3; t++) if (en[t]) begin
      if (t == 0 && !byp && (fmt == FMT_ESF || fmt == FMT_T1DM)) begin
        if (fmt == FMT_ESF ? fl : (s == LAST_CH && b == DBIT_IDX && !fp))
          return 1;
      end else if (!(t == 0 && (fmt == FMT_SF || fmt == FMT_SLC96)) &&
                   !(fp && !byp) && s == asg[t][4:0] && msk[t][b] &&
                   (fo ? asg[t][ASG_ODD] : asg[t][ASG_EVEN]))
        return t + 1;
    end
    return 0;
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(logic w, logic [7:0] idx, logic [7:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      complete_run();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Slots kept apart so no transmitter is starved by a lower-numbered one
  task automatic cfg(int f, logic b, logic [2:0] e, logic full);
    watch = 1'b0;
    fmt   = htx_fmt_e'(f);
    byp   = b;
    en    = e;
    isT1 <= (fmt != FMT_E1);
    apb(1'b1, IDX_FORMAT, {4'h0, b, fmt});
    for (int t = 0; t < 3; t++) begin
      asg[t] = {rnd[1:0] == 2'b00 ? 2'b11 : rnd[1:0], 1'b0,
                5'(int'(rnd[10:8]) % 7 + 7 * t)};
      msk[t] = full ? 8'hFF : rnd[23:16] | (8'h01 << rnd[26:24]);
      apb(1'b1, IDX_ASSIGN[t], asg[t]);
      apb(1'b1, IDX_BITMASK[t], msk[t]);
      q[t].delete();
    end
    apb(1'b1, IDX_EN, {5'h00, e});
    @(posedge clk);
    watch <= 1'b1;
  endtask

  always @(posedge clk) begin
    if (watch) begin
      chk(outValid, pv);
      if (pv && po == 0) chk(outBit, pb);
      else if (pv) q[po-1].push_back(outBit);
    end
    pv = inValid;
    pb = inBit;
    po = owner(frameOdd, slotIdx, bitIdx, framingPos, facilityLinkPos);
  end

  // Any eight-bit window of an idle flag stream holds exactly six ones
  task automatic flags(int t);
    int ones;
    chk(q[t].size() >= 16, 1'b1);
    for (int i = 8; i + 8 <= q[t].size(); i += 8) begin
      ones = 0;
      for (int j = 0; j < 8; j++) ones += q[t][i+j];
      chk(ones, 6);
    end
  endtask

  task automatic decode(int t);
    logic d [$];
    int   ones;
    int   n;
    logic seen;
    ones = 0;
    n    = 0;
    seen = 1'b0;
    for (int i = 0; i < q[t].size(); i++) begin
      if (q[t][i]) begin
        ones++;
        d.push_back(1'b1);
      end else if (ones == 5) ones = 0;
      else if (ones == 6) begin
        ones = 0;
        repeat (7) if (d.size() > 0) void'(d.pop_back());
        if (seen) while (d.size() >= 8) begin
          for (int j = 0; j < 8; j++) v[j] = d.pop_front();
          if (n < 5) chk(v, want[n]);
          n++;
        end
        d.delete();
        seen = 1'b1;
      end else begin
        ones = 0;
        d.push_back(1'b0);
      end
    end
    chk(n, 5);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    {rst_n, psel, penable, pwrite, isT1, slow, srcBit, watch} = '0;
    {pv, pb, byp, en, paddr, pwdata, po, n_fail, tests_run} = '0;
    rnd  = 32'h000138AC;
    fmt  = FMT_E1;
    want = '{8'hFF, 8'h7E, 8'h00, 8'h1F, 8'hF8};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk(irq, 1'b0);
    for (int i = 0; i < NTX; i++) begin
      apb(1'b0, IDX_CTRL[i], 8'h00);
      chk(rd, RST_REG);
    end
    apb(1'b0, IDX_FORMAT, 8'h00);
    chk(rd, RST_REG);
    apb(1'b1, 8'h00, 8'hFF);
    chk(er, 1'b1);
    apb(1'b0, 8'h00, 8'h00);
    chk({er, rd}, 9'h100);
    apb(1'b0, IDX_FIFO_ST[0], 8'h00);
    v = rd;
    apb(1'b1, IDX_FIFO_ST[0], ~v);
    apb(1'b0, IDX_FIFO_ST[0], 8'h00);
    chk(rd, v);
    for (int f = 0; f < 6; f++) begin
      cfg(f == 5 ? 0 : f, f == 5, 3'b111, 1'b0);
      apb(1'b0, IDX_ASSIGN[0], 8'h00);
      chk(rd, asg[0]);
      apb(1'b0, IDX_BITMASK[2], 8'h00);
      chk(rd, msk[2]);
      repeat (10000) @(posedge clk);
      for (int t = 0; t < 3; t++)
        if (!(t == 0 && (f == 1 || f == 2))) flags(t);
    end
    cfg(4, 1'b0, 3'b000, 1'b0);
    repeat (600) @(posedge clk);
    slow <= 1'b1;
    want[2] = rnd[15:8];
    cfg(4, 1'b0, 3'b010, 1'b1);
    for (int i = 0; i < 5; i++) begin
      k = 0;
      do begin
        apb(1'b0, IDX_FIFO_ST[1], 8'h00);
        k++;
      end while (!rd[ST_READY] && k < 2000);
      chk(rd[ST_READY], 1'b1);
      if (k >= 2000) complete_run();
      if (i == 4) apb(1'b1, IDX_CTRL[1], 8'h02);
      apb(1'b1, IDX_OCTET[1], want[i]);
    end
    repeat (12000) @(posedge clk);
    decode(1);
    slow <= 1'b0;
    cfg(4, 1'b0, 3'b100, 1'b1);
    apb(1'b1, IDX_OCTET[2], rnd[7:0]);
    k = 0;
    do begin
      apb(1'b0, IDX_EVACK, 8'h00);
      k++;
    end while (!rd[5] && k < 2000);
    chk(rd[5], 1'b1);
    if (k >= 2000) complete_run();
    chk(irq, 1'b0);
    apb(1'b0, IDX_EVFLAG3, 8'h00);
    chk(rd[EV_UNDER], 1'b1);
    apb(1'b1, IDX_EVMASK[2], 8'h02);
    @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, IDX_EVACK, 8'h20);
    @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b0, IDX_EVACK, 8'h00);
    chk(rd[5], 1'b0);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
